// >>> src/boot_image_loader.sv
// Boot sequencer: picks a source, loads a length-prefixed image, checks it, starts it.
//
// Added by the designer: the strobed register port and the register addresses.
module boot_image_loader (
	input  wire logic        clk_in,              // Tile clock, 10 MHz.
	input  wire logic        rstn_in,             // Chip reset, active low.
	input  wire logic        boot_strap_2_in,     // Boot strap pin 2.
	input  wire logic        boot_strap_1_in,     // Boot strap pin 1.
	input  wire logic        boot_strap_0_in,     // Boot strap pin 0.
	input  wire logic [31:0] sec_word_in,         // Security word loaded from OTP.
	input  wire logic [31:0] otp_data_in,         // OTP row read data.
	output logic [boot_pkg::OTP_AW-1:0] otp_addr_out, // OTP row address.
	output logic        pin_select_a_out,    // Flash select, active low.
	output logic        pin_select_a_oe_out, // Select pin drive enable.
	input  wire logic        pin_clock_in,        // Serial clock pin level.
	output logic        pin_clock_out,       // Serial clock drive value.
	output logic        pin_clock_oe_out,    // Serial clock drive enable.
	input  wire logic        pin_data_in_in,      // MISO, or slave select.
	input  wire logic        pin_data_out_in,     // Slave data pin level.
	output logic        pin_data_out_out,    // MOSI drive value.
	output logic        pin_data_out_oe_out, // MOSI drive enable.
	input  wire logic [3:0]  quad_data_in,        // Quad data pin levels.
	output logic [3:0]  quad_data_out,       // Quad data drive values.
	output logic [3:0]  quad_data_oe_out,    // Quad data drive enables.
	output logic        gpio_pulldown_out,   // Pull-downs on all pins.
	output logic        link_pulldown_out,   // Pull-downs on link pins.
	input  wire logic [1:0]  link_rx_in,          // Link receive wires.
	output logic [1:0]  link_tx_out,         // Link transmit wires.
	output logic        link_tx_oe_out,      // Link transmit enable.
	output logic        run_out,             // Start execution at word 0.
	output logic        halt_out,            // Boot failed, held halted.
	output logic        debug_lock_out,      // Debug port blocked.
	output logic        switch_lock_out,     // Switch access blocked.
	output logic        otp_redundant_out,   // OTP redundant rows on.
	output logic [3:0]  sector_lock_out,     // Per-sector program locks.
	output logic        sec_update_lock_out, // Security word updates blocked.
	output logic        debug_otp_lock_out,  // Debug OTP access blocked.
	output logic [9:0]  usercode_ext_out,    // User code extension.
	input  wire logic [boot_pkg::RAM_AW-1:0] fetch_addr_in, // Fetch word address.
	output logic [31:0] fetch_data_out,      // Fetch word data.
	input  wire logic [7:0]  reg_addr_in,         // Register byte address.
	input  wire logic [31:0] reg_wdata_in,        // Register write data.
	input  wire logic        reg_wr_in,           // Register write strobe.
	input  wire logic        reg_rd_in,           // Register read strobe.
	output logic [31:0] reg_rdata_out        // Register read data.
);
	typedef struct packed {
		boot_pkg::state_t          st;
		boot_pkg::phase_t          ph;
		logic [11:0]               y1;
		logic [11:0]               y2;
		logic [11:0]               yp;
		logic [7:0]                cnt;
		logic [2:0]                src;
		logic                      otp;
		logic [31:0]               sec;
		logic [3:0]                sl;
		logic                      pd;
		logic                      lpd;
		logic                      sel;
		logic                      oe_sel;
		logic                      sclk;
		logic                      oe_clk;
		logic                      mosi;
		logic                      oe_do;
		logic [3:0]                qoe;
		logic [31:0]               sh;
		logic [5:0]                bitc;
		logic [7:0]                by;
		logic [3:0]                bc;
		logic [1:0]                bk;
		logic [31:0]               w;
		logic [31:0]               s;
		logic [31:0]               crc;
		logic [boot_pkg::RAM_AW-1:0] wa;
		logic                      we;
		logic [boot_pkg::OTP_AW-1:0] oa;
		logic                      ov;
		logic [1:0]                ob;
		logic [8:0]                lsh;
		logic [8:0]                tsh;
		logic [1:0]                tx;
		logic                      oe_tx;
		logic                      ackn;
		logic                      ok;
		logic                      run;
		logic                      halt;
		logic [31:0]               rd;
	} regs_t;

	regs_t r;
	regs_t n;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] v;
		v = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++)
		begin
			v = v[0] ? ((v >> 1) ^ boot_pkg::CRC_POLY) : (v >> 1);
		end
		return v;
	endfunction

	always_comb
	begin
		logic       bev;
		logic [7:0] bv;
		logic       tick;
		logic [1:0] tog;
		logic [7:0] half;
		bev = 1'b0;
		bv = 8'h00;
		n = r;
		n.y1 = {pin_data_out_in, link_rx_in, quad_data_in, pin_clock_in, pin_data_in_in,
			boot_strap_2_in, boot_strap_1_in, boot_strap_0_in};
		n.y2 = r.y1;
		n.yp = r.y2;
		n.pd = 1'b0;
		n.we = 1'b0;
		n.rd = 32'h00000000;
		half = (r.src == boot_pkg::SRC_QSPI) ? boot_pkg::QSPI_HALF : boot_pkg::SPI_HALF;
		tick = (r.cnt == half - 8'h01);
		tog = r.y2[boot_pkg::Y_RX +: 2] ^ r.yp[boot_pkg::Y_RX +: 2];
		unique case (r.st)
			boot_pkg::ST_RST:
			begin
				n.sec = sec_word_in;
				n.cnt = 8'h00;
				n.st = boot_pkg::ST_WAIT;
			end
			boot_pkg::ST_WAIT:
			begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == boot_pkg::RESET_N - 8'h01)
				begin
					n.cnt = 8'h00;
					n.otp = r.sec[boot_pkg::SEC_BOOT];
					n.src = r.y2[boot_pkg::Y_STRAP +: 3];
					n.ph = (n.src == boot_pkg::SRC_LINK && !n.otp) ? boot_pkg::P_ACKW
						: boot_pkg::P_CNT;
					n.crc = boot_pkg::CRC_INIT;
					n.wa = '1;
					n.bk = 2'h0;
					n.bc = 4'h0;
					n.oa = '0;
					n.ov = 1'b0;
					n.ob = 2'h0;
					n.st = boot_pkg::ST_CMD;
				end
			end
			boot_pkg::ST_CMD:
			begin
				if (r.otp)
				begin
					n.st = boot_pkg::ST_LOAD;
				end
				else
				begin
					unique case (r.src)
						boot_pkg::SRC_QSPI, boot_pkg::SRC_SPI:
						begin
							if (!r.oe_sel)
							begin
								n.oe_sel = 1'b1;
								n.oe_clk = 1'b1;
								n.sel = 1'b0;
								n.sclk = 1'b0;
								n.sh = boot_pkg::READ_WORD;
								n.bitc = boot_pkg::CMD_BITS;
								n.oe_do = (r.src == boot_pkg::SRC_SPI);
								n.qoe = {3'b000, r.src == boot_pkg::SRC_QSPI};
								n.cnt = 8'h00;
							end
							else
							begin
								n.cnt = r.cnt + 8'h01;
								if (tick)
								begin
									n.cnt = 8'h00;
									n.sclk = !r.sclk;
									if (r.sclk)
									begin
										n.sh = r.sh << 1;
										n.bitc = r.bitc - 6'h01;
										if (r.bitc == 6'h01)
										begin
											n.qoe = 4'h0;
											n.st = boot_pkg::ST_LOAD;
										end
									end
								end
							end
						end
						boot_pkg::SRC_SLV:
						begin
							n.st = boot_pkg::ST_LOAD;
						end
						boot_pkg::SRC_LINK:
						begin
							n.cnt = r.cnt + 8'h01;
							if (r.cnt == boot_pkg::LINK_N - 8'h01)
							begin
								n.lpd = 1'b0;
								n.oe_tx = 1'b1;
								n.tx = 2'b00;
								n.bitc = boot_pkg::TOK_BITS;
								n.st = boot_pkg::ST_LOAD;
							end
						end
						default:
						begin
							n.st = boot_pkg::ST_HALT;
						end
					endcase
				end
			end
			boot_pkg::ST_LOAD:
			begin
				if (r.otp)
				begin
					if (!r.ov)
					begin
						n.ov = 1'b1;
					end
					else
					begin
						bev = 1'b1;
						bv = 8'(otp_data_in >> {r.ob, 3'b000});
						n.ob = r.ob + 2'h1;
						if (r.ob == 2'h3)
						begin
							n.oa = r.oa + 1'b1;
							n.ov = 1'b0;
						end
					end
				end
				else if (r.src == boot_pkg::SRC_LINK)
				begin
					if (|tog)
					begin
						n.lsh = {tog[1], r.lsh[8:1]};
						n.bitc = r.bitc - 6'h01;
						if (r.bitc == 6'h01)
						begin
							n.bitc = boot_pkg::TOK_BITS;
							if (!n.lsh[0])
							begin
								bev = 1'b1;
								bv = n.lsh[8:1];
							end
							else if (r.ph == boot_pkg::P_END && n.lsh[8:1] == boot_pkg::END_TOK)
							begin
								n.tsh = {boot_pkg::END_TOK, 1'b1};
								n.cnt = 8'h00;
								n.st = boot_pkg::ST_ACK;
							end
						end
					end
				end
				else if (r.src == boot_pkg::SRC_SLV)
				begin
					if (r.y2[boot_pkg::Y_DIN])
					begin
						n.bc = 4'h0;
					end
					else if (r.y2[boot_pkg::Y_CLK] && !r.yp[boot_pkg::Y_CLK])
					begin
						n.by = {r.y2[boot_pkg::Y_DO], r.by[7:1]};
						n.bc = r.bc + 4'h1;
					end
				end
				else
				begin
					n.cnt = r.cnt + 8'h01;
					if (tick)
					begin
						n.cnt = 8'h00;
						n.sclk = !r.sclk;
						if (!r.sclk && r.src == boot_pkg::SRC_QSPI)
						begin
							n.by = {r.y2[boot_pkg::Y_Q +: 4], r.by[7:4]};
							n.bc = r.bc + 4'h4;
						end
						else if (!r.sclk)
						begin
							n.by = {r.y2[boot_pkg::Y_DIN], r.by[7:1]};
							n.bc = r.bc + 4'h1;
						end
					end
				end
				if (n.bc == boot_pkg::BYTE_BITS)
				begin
					n.bc = 4'h0;
					bev = 1'b1;
					bv = n.by;
				end
				if (bev)
				begin
					n.w = {bv, r.w[31:8]};
					n.bk = r.bk + 2'h1;
					if (r.ph == boot_pkg::P_CNT || r.ph == boot_pkg::P_PROG)
					begin
						n.crc = crc_byte(r.crc, bv);
					end
					if (r.bk == 2'h3)
					begin
						unique case (r.ph)
							boot_pkg::P_ACKW:
							begin
								n.ackn = (n.w != boot_pkg::NULL_CHAN);
								n.ph = boot_pkg::P_CNT;
							end
							boot_pkg::P_CNT:
							begin
								n.s = n.w;
								n.ph = (n.w == 32'h00000000) ? boot_pkg::P_CRC : boot_pkg::P_PROG;
							end
							boot_pkg::P_PROG:
							begin
								n.we = 1'b1;
								n.wa = r.wa + 1'b1;
								n.s = r.s - 32'h00000001;
								if (r.s == 32'h00000001)
								begin
									n.ph = boot_pkg::P_CRC;
								end
							end
							boot_pkg::P_CRC:
							begin
								n.ok = (n.w == boot_pkg::CRC_SKIP) || (n.w == ~r.crc);
								if (r.src == boot_pkg::SRC_LINK && !r.otp)
								begin
									n.ph = boot_pkg::P_END;
								end
								else
								begin
									n.st = n.ok ? boot_pkg::ST_RUN : boot_pkg::ST_HALT;
								end
							end
							default:
							begin
								n.ph = r.ph;
							end
						endcase
					end
				end
			end
			boot_pkg::ST_ACK:
			begin
				if (!r.ackn)
				begin
					n.st = r.ok ? boot_pkg::ST_RUN : boot_pkg::ST_HALT;
				end
				else
				begin
					n.cnt = r.cnt + 8'h01;
					if (r.cnt == boot_pkg::LINK_BIT - 8'h01)
					begin
						n.cnt = 8'h00;
						n.tx = r.tx ^ (r.tsh[0] ? 2'b10 : 2'b01);
						n.tsh = r.tsh >> 1;
						n.bitc = r.bitc - 6'h01;
						if (r.bitc == 6'h01)
						begin
							n.st = r.ok ? boot_pkg::ST_RUN : boot_pkg::ST_HALT;
						end
					end
				end
			end
			boot_pkg::ST_RUN, boot_pkg::ST_HALT:
			begin
				n.sel = 1'b1;
				n.oe_sel = 1'b0;
				n.oe_clk = 1'b0;
				n.oe_do = 1'b0;
				n.sclk = 1'b0;
				n.run = (r.st == boot_pkg::ST_RUN);
				n.halt = (r.st == boot_pkg::ST_HALT);
				if (reg_wr_in && reg_addr_in == boot_pkg::REG_CTRL && reg_wdata_in[0])
				begin
					n.run = 1'b0;
					n.halt = 1'b0;
					n.cnt = 8'h00;
					n.st = boot_pkg::ST_WAIT;
				end
			end
			default:
			begin
				n.st = boot_pkg::ST_HALT;
			end
		endcase
		n.mosi = n.sh[31];
		n.sl = r.sec[boot_pkg::SEC_SECT +: 4] | {4{r.sec[boot_pkg::SEC_MASTER]}};
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				boot_pkg::REG_SEC: n.rd = r.sec;
				boot_pkg::REG_STAT: n.rd = 32'({r.halt, r.run, r.ok, r.ph, r.otp, r.src, r.st});
				boot_pkg::REG_CRC: n.rd = r.crc;
				default: n.rd = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			r <= '0;
			r.pd <= 1'b1;
			r.lpd <= 1'b1;
			r.sel <= 1'b1;
		end
		else
		begin
			r <= n;
		end
	end

	boot_ram u_ram (
		.clk_in    (clk_in),
		.we_in     (r.we),
		.waddr_in  (r.wa),
		.wdata_in  (r.w),
		.raddr_in  (fetch_addr_in),
		.rdata_out (fetch_data_out)
	);

	assign otp_addr_out        = r.oa;
	assign pin_select_a_out    = r.sel;
	assign pin_select_a_oe_out = r.oe_sel;
	assign pin_clock_out       = r.sclk;
	assign pin_clock_oe_out    = r.oe_clk;
	assign pin_data_out_out    = r.mosi;
	assign pin_data_out_oe_out = r.oe_do;
	assign quad_data_out       = {3'b000, r.mosi};
	assign quad_data_oe_out    = r.qoe;
	assign gpio_pulldown_out   = r.pd;
	assign link_pulldown_out   = r.lpd;
	assign link_tx_out         = r.tx;
	assign link_tx_oe_out      = r.oe_tx;
	assign run_out             = r.run;
	assign halt_out            = r.halt;
	assign debug_lock_out      = r.sec[boot_pkg::SEC_DBG];
	assign switch_lock_out     = r.sec[boot_pkg::SEC_SW];
	assign otp_redundant_out   = r.sec[boot_pkg::SEC_RED];
	assign sector_lock_out     = r.sl;
	assign sec_update_lock_out = r.sec[boot_pkg::SEC_MASTER];
	assign debug_otp_lock_out  = r.sec[boot_pkg::SEC_DOTP];
	assign usercode_ext_out    = r.sec[31:boot_pkg::SEC_UID];
	assign reg_rdata_out       = r.rd;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	sequence s_ack_done;
		##[1:100] (r.st == boot_pkg::ST_RUN || r.st == boot_pkg::ST_HALT);
	endsequence
	sequence s_wait_end;
		(r.st == boot_pkg::ST_WAIT) && (r.cnt == boot_pkg::RESET_N - 8'h01);
	endsequence

	property p_pd_off;
		(r.st == boot_pkg::ST_WAIT) |-> !r.pd;
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("pull-down still on after reset");
	property p_wait;
		$rose(r.st == boot_pkg::ST_CMD) |-> $past(r.cnt) == boot_pkg::RESET_N - 8'h01;
	endproperty
	a_wait: assert property (p_wait) else $error("boot started early");
	property p_otp;
		s_wait_end ##1 r.sec[boot_pkg::SEC_BOOT] |-> r.otp;
	endproperty
	a_otp: assert property (p_otp) else $error("secure boot not taken");
	property p_cmd;
		$rose(r.oe_sel) |-> r.sh == boot_pkg::READ_WORD && !r.sel && !r.sclk;
	endproperty
	a_cmd: assert property (p_cmd) else $error("bad read command start");
	property p_qspi_pins;
		(r.st == boot_pkg::ST_LOAD && !r.otp && r.src == boot_pkg::SRC_QSPI)
			|-> r.oe_sel && r.oe_clk && r.qoe == 4'h0;
	endproperty
	a_qspi_pins: assert property (p_qspi_pins) else $error("quad pins wrong");
	property p_slave;
		(r.st == boot_pkg::ST_LOAD && !r.otp && r.src == boot_pkg::SRC_SLV)
			|-> !r.oe_clk && !r.oe_do && !r.oe_sel;
	endproperty
	a_slave: assert property (p_slave) else $error("slave drives a pin");
	property p_link;
		(r.st == boot_pkg::ST_LOAD && !r.otp && r.src == boot_pkg::SRC_LINK)
			|-> !r.lpd && r.oe_tx && r.tx == 2'b00;
	endproperty
	a_link: assert property (p_link) else $error("link not enabled");
	property p_ack;
		$rose(r.st == boot_pkg::ST_ACK) |-> s_ack_done;
	endproperty
	a_ack: assert property (p_ack) else $error("end token not sent");
	property p_run;
		$rose(r.run) |-> r.w == boot_pkg::CRC_SKIP || r.w == ~r.crc;
	endproperty
	a_run: assert property (p_run) else $error("ran with bad CRC");
endmodule // boot_image_loader

// >>> src/boot_pkg.sv
// Constants, encodings and timing shared by the boot loader files.
package boot_pkg;
	localparam int CLK_MHZ     = 10;
	localparam int CLK_NS      = 100;
	localparam int RESET_US    = 15;
	localparam int RESET_CYC   = RESET_US * CLK_MHZ;
	localparam int LINK_US     = 2;
	localparam int LINK_CYC    = LINK_US * CLK_MHZ;
	localparam int LINK_BIT_NS = 800;
	localparam int CORE_KHZ    = 400000;
	localparam int QSPI_KHZ    = 50000;
	localparam int SPI_KHZ     = 2500;
	localparam logic [7:0] RESET_N   = 8'(RESET_CYC);
	localparam logic [7:0] LINK_N    = 8'(LINK_CYC);
	localparam logic [7:0] LINK_BIT  = 8'(LINK_BIT_NS / CLK_NS);
	localparam logic [7:0] QSPI_HALF = 8'(CORE_KHZ / QSPI_KHZ / 2);
	localparam logic [7:0] SPI_HALF  = 8'(CORE_KHZ / SPI_KHZ / 2);
	localparam int RAM_AW = 16;
	localparam int OTP_AW = 11;
	localparam logic [31:0] READ_WORD = 32'h03000000;
	localparam logic [5:0]  CMD_BITS  = 6'h20;
	localparam logic [5:0]  TOK_BITS  = 6'h09;
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [31:0] CRC_POLY  = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT  = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_SKIP  = 32'h0D15AB1E;
	localparam logic [31:0] NULL_CHAN = 32'h0000FF02;
	localparam logic [7:0]  END_TOK   = 8'h01;
	localparam int SEC_DBG    = 0;
	localparam int SEC_SW     = 1;
	localparam int SEC_BOOT   = 5;
	localparam int SEC_RED    = 7;
	localparam int SEC_SECT   = 8;
	localparam int SEC_MASTER = 12;
	localparam int SEC_DOTP   = 13;
	localparam int SEC_UID    = 22;
	localparam int Y_STRAP = 0;
	localparam int Y_DIN   = 3;
	localparam int Y_CLK   = 4;
	localparam int Y_Q     = 5;
	localparam int Y_RX    = 9;
	localparam int Y_DO    = 11;
	localparam logic [7:0] REG_SEC  = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_CRC  = 8'h0C;
	localparam logic [2:0] SRC_QSPI = 3'h0;
	localparam logic [2:0] SRC_SPI  = 3'h1;
	localparam logic [2:0] SRC_SLV  = 3'h2;
	localparam logic [2:0] SRC_LINK = 3'h4;
	typedef enum logic [2:0] {
		ST_RST  = 3'b000,
		ST_WAIT = 3'b001,
		ST_CMD  = 3'b011,
		ST_LOAD = 3'b010,
		ST_ACK  = 3'b110,
		ST_RUN  = 3'b111,
		ST_HALT = 3'b101
	} state_t;
	typedef enum logic [2:0] {
		P_ACKW = 3'h0,
		P_CNT  = 3'h1,
		P_PROG = 3'h2,
		P_CRC  = 3'h3,
		P_END  = 3'h4
	} phase_t;
endpackage

// >>> src/boot_ram.sv
// Program RAM with one write port and one registered read port.
module boot_ram (
	input  wire logic                        clk_in,   // Tile clock.
	input  wire logic                        we_in,    // Write strobe.
	input  wire logic [boot_pkg::RAM_AW-1:0] waddr_in, // Write word address.
	input  wire logic [31:0]                 wdata_in, // Write word.
	input  wire logic [boot_pkg::RAM_AW-1:0] raddr_in, // Read word address.
	output logic      [31:0]                 rdata_out // Read word, one cycle late.
);
	logic [31:0] mem [0:(1 << boot_pkg::RAM_AW) - 1];

	always_ff @(posedge clk_in)
	begin
		if (we_in)
		begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule // boot_ram

// >>> testbench/boot_image_loader_tb.sv
// Self-checking bench: reset, security, registers, QSPI, SPI, slave, link and OTP boots.
module boot_image_loader_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [95:0] BODY = {32'h01234567, 32'hA5C30F81, 32'h00000002};
	logic clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic run_out, halt_out, gpio_pulldown_out, pin_select_a_out, pin_select_a_oe_out;
	logic pin_clock_out, pin_clock_oe_out, miso, debug_lock_out, switch_lock_out;
	logic otp_redundant_out, sec_update_lock_out, debug_otp_lock_out, sel_w, sclk_w;
	logic ext_sel, ext_clk, ext_dat, mosi_w, do_val, do_oe, lpd, tx_oe;
	logic [1:0]   rx, tx;
	logic [2:0]   strap = 3'h0;
	logic [3:0]   quad, sector_lock_out, qdo, qoe;
	logic [8:0]   rep;
	logic [31:0]  cmd;
	logic [7:0]   reg_addr_in = 8'h00;
	logic [9:0]   usercode_ext_out;
	logic [10:0]  otp_addr_out;
	logic [15:0]  fetch_addr_in = 16'h0000;
	logic [31:0]  sec_word_in = 32'h00000000, otp_data_in = 32'h00000000;
	logic [31:0]  reg_wdata_in = 32'h00000000, reg_rdata_out, fetch_data_out, d;
	logic [127:0] img;
	int err_count = 0;
	int cmp_count = 0;
	always #50 clk_in = ~clk_in;
	// The select line has an external pull-up; the clock line idles low.
	assign sel_w = pin_select_a_oe_out ? pin_select_a_out : 1'b1;
	assign sclk_w = pin_clock_oe_out ? pin_clock_out : 1'b0;
	// A floating command line reads high, so a missing drive enable spoils the command.
	assign mosi_w = (strap == 3'h0) ? (qoe[0] ? qdo[0] : 1'b1) : (do_oe ? do_val : 1'b1);
	always @(posedge clk_in) otp_data_in <= img[otp_addr_out[1:0] * 32 +: 32];
	flash_model flash (.sel_n_in(sel_w), .sclk_in(sclk_w), .quad_in(strap == 3'h0),
		.image_in(img), .miso_out(miso), .quad_out(quad), .mosi_in(mosi_w),
		.slave_in(strap == 3'h2), .link_in(strap == 3'h4), .tx_in(tx), .cmd_out(cmd),
		.ext_sel_n_out(ext_sel), .ext_clk_out(ext_clk), .ext_data_out(ext_dat), .rx_out(rx),
		.rep_out(rep));
	boot_image_loader DUT (.clk_in(clk_in), .rstn_in(rstn_in), .boot_strap_2_in(strap[2]),
		.boot_strap_1_in(strap[1]), .boot_strap_0_in(strap[0]), .sec_word_in(sec_word_in),
		.otp_data_in(otp_data_in), .otp_addr_out(otp_addr_out),
		.pin_select_a_out(pin_select_a_out), .pin_select_a_oe_out(pin_select_a_oe_out),
		.pin_clock_in(strap == 3'h2 ? ext_clk : sclk_w), .pin_clock_out(pin_clock_out),
		.pin_clock_oe_out(pin_clock_oe_out), .pin_data_in_in(strap == 3'h2 ? ext_sel : miso),
		.pin_data_out_in(ext_dat), .pin_data_out_out(do_val), .pin_data_out_oe_out(do_oe),
		.quad_data_in(quad), .quad_data_out(qdo), .quad_data_oe_out(qoe),
		.gpio_pulldown_out(gpio_pulldown_out), .link_pulldown_out(lpd), .link_rx_in(rx),
		.link_tx_out(tx), .link_tx_oe_out(tx_oe), .run_out(run_out), .halt_out(halt_out),
		.debug_lock_out(debug_lock_out), .switch_lock_out(switch_lock_out),
		.otp_redundant_out(otp_redundant_out), .sector_lock_out(sector_lock_out),
		.sec_update_lock_out(sec_update_lock_out), .debug_otp_lock_out(debug_otp_lock_out),
		.usercode_ext_out(usercode_ext_out), .fetch_addr_in(fetch_addr_in),
		.fetch_data_out(fetch_data_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
	function automatic logic [31:0] crc_of(input logic [95:0] s);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < 96; i++)
			c = (c >> 1) ^ ((c[0] ^ s[i]) ? 32'hEDB88320 : 32'h00000000);
		return ~c;
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h", $time, m, got);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		chk_word({31'h0, got}, {31'h0, exp}, m);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
		@(posedge clk_in);
	endtask
	task automatic do_reset(input logic [31:0] sec);
		sec_word_in <= sec;
		rstn_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		chk_bit(gpio_pulldown_out, 1'b1, "pull-down in reset");
		rstn_in <= 1'b1;
		repeat (140) @(posedge clk_in);
		chk_bit(pin_select_a_oe_out, 1'b0, "boot started early");
		chk_bit(gpio_pulldown_out, 1'b0, "pull-down after reset");
	endtask
	task automatic boot(input logic [31:0] trl, input logic [2:0] st, input logic rs,
		input logic ok);
		int n;
		img = {trl, BODY};
		strap <= st;
		if (rs)
		begin
			reg_addr_in <= 8'h08;
			reg_wdata_in <= 32'h00000001;
			reg_wr_in <= 1'b1;
			@(posedge clk_in);
			reg_wr_in <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		n = 0;
		while (run_out !== 1'b1 && halt_out !== 1'b1 && n < 40000)
		begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 40000)
		begin
			err_count++;
			give_verdict();
		end
		#1 chk_bit(run_out, ok, "run");
		chk_bit(halt_out, !ok, "halt");
		if (st < 3'h2)
			chk_word(cmd, 32'h03000000, "read command");
		if (st == 3'h4)
		begin
			chk_word({23'h0, rep}, 32'h00000003, "end token reply");
			chk_bit(lpd, 1'b0, "link pull-down");
			chk_bit(tx_oe, 1'b1, "link drive");
		end
		for (int i = 0; i < 2 && ok; i++)
		begin
			@(posedge clk_in);
			fetch_addr_in <= 16'(i);
			repeat (2) @(posedge clk_in);
			#1 chk_word(fetch_data_out, BODY[32 * i + 32 +: 32], "fetch");
		end
		@(posedge clk_in);
		rd(8'h0C);
		chk_word(d, ~crc_of(BODY), "crc register");
		rd(8'h04);
		chk_word({30'h0, d[12:11]}, {30'h0, !ok, ok}, "status");
		$display("boot test strap %h done", st);
	endtask
	initial
	begin
		img = {crc_of(BODY), BODY};
		do_reset(32'hABC02A83);
		chk_bit(debug_lock_out, 1'b1, "debug lock");
		chk_bit(switch_lock_out, 1'b1, "switch lock");
		chk_bit(otp_redundant_out, 1'b1, "redundant rows");
		chk_word({28'h0, sector_lock_out}, 32'h0000000A, "sector locks");
		chk_bit(sec_update_lock_out, 1'b0, "master lock");
		chk_bit(debug_otp_lock_out, 1'b1, "debug otp lock");
		chk_word({22'h0, usercode_ext_out}, 32'h000002AF, "user code");
		rd(8'h00);
		chk_word(d, 32'hABC02A83, "security read");
		rd(8'h10);
		chk_word(d, 32'h00000000, "unmapped read");
		$display("reset and register test done");
		boot(crc_of(BODY), 3'h0, 1'b0, 1'b1);
		boot(crc_of(BODY) ^ 32'h00000100, 3'h1, 1'b1, 1'b0);
		boot(32'h0D15AB1E, 3'h1, 1'b1, 1'b1);
		boot(crc_of(BODY), 3'h2, 1'b1, 1'b1);
		boot(crc_of(BODY), 3'h4, 1'b1, 1'b1);
		strap <= 3'h3;
		do_reset(32'h00000020);
		boot(crc_of(BODY), 3'h3, 1'b0, 1'b1);
		give_verdict();
	end
endmodule // boot_image_loader_tb

// >>> testbench/flash_model.sv
// Far-side models: serial flash, external SPI master and remote link chip.
module flash_model (
	input  wire logic         sel_n_in,      // Select, active low.
	input  wire logic         sclk_in,       // Serial clock, mode 0.
	input  wire logic         quad_in,       // High for four-line reads.
	input  wire logic [127:0] image_in,      // Image in stream order from bit 0.
	input  wire logic         mosi_in,       // Command line from the loader.
	input  wire logic         slave_in,      // Rises to start an external-master session.
	input  wire logic         link_in,       // Rises to start a link boot session.
	input  wire logic [1:0]   tx_in,         // Loader's link transmit wires.
	output logic              miso_out,      // Single-line data.
	output logic [3:0]        quad_out,      // Four-line data.
	output logic [31:0]       cmd_out,       // Command bits seen in the last session.
	output logic              ext_sel_n_out, // External master select, active low.
	output logic              ext_clk_out,   // External master clock, mode 1/1.
	output logic              ext_data_out,  // External master data.
	output logic [1:0]        rx_out,        // Loader's link receive wires.
	output logic [8:0]        rep_out        // Token sent back, first bit in bit 0.
);
	timeunit 1ns;
	timeprecision 1ns;
	// A real acknowledge channel, so the loader must answer with a token.
	localparam logic [31:0] ACK_CHAN = 32'h00010002;
	int falls = 0;
	int pos;
	initial
	begin
		miso_out = 1'b0;
		quad_out = 4'h0;
		cmd_out = 32'h00000000;
		ext_sel_n_out = 1'b1;
		ext_clk_out = 1'b1;
		ext_data_out = 1'b0;
		rx_out = 2'b00;
		rep_out = 9'h000;
	end
	always @(posedge sclk_in)
	begin
		if (!sel_n_in && falls < 32)
		begin
			cmd_out = {cmd_out[30:0], mosi_in};
		end
	end
	always @(negedge sel_n_in) falls = 0;
	// A released data line does not keep its value, so show the inverse.
	always @(posedge sel_n_in)
	begin
		miso_out = ~miso_out;
		quad_out = ~quad_out;
	end
	// Data move on the falling edge so they are settled long before the next rise.
	always @(negedge sclk_in)
	begin
		if (!sel_n_in)
		begin
			falls++;
			pos = falls - 32;
			if (pos >= 0 && quad_in)
				quad_out = image_in[(pos % 32) * 4 +: 4];
			else if (pos >= 0)
				miso_out = image_in[pos % 128];
		end
	end
	// The external master waits until the loader has surely reached its load phase.
	always @(posedge slave_in)
	begin
		#20000 ext_sel_n_out = 1'b0;
		for (int i = 0; i < 128; i++)
		begin
			#400 ext_clk_out = 1'b0;
			ext_data_out = image_in[i];
			#400 ext_clk_out = 1'b1;
		end
		#400 ext_sel_n_out = 1'b1;
		ext_data_out = ~ext_data_out;
	end
	task automatic send_tok(input logic ctl, input logic [7:0] v);
		logic [8:0] t;
		t = {v, ctl};
		for (int i = 0; i < 9; i++)
		begin
			#400;
			if (t[i])
				rx_out[1] = ~rx_out[1];
			else
				rx_out[0] = ~rx_out[0];
		end
	endtask
	// Receive wires stay low until well after the loader has enabled its link.
	always @(posedge link_in)
	begin
		rep_out = 9'h000;
		#20000;
		for (int k = 0; k < 4; k++)
			send_tok(1'b0, ACK_CHAN[8 * k +: 8]);
		for (int k = 0; k < 16; k++)
			send_tok(1'b0, image_in[8 * k +: 8]);
		send_tok(1'b1, 8'h01);
	end
	always @(tx_in[0]) rep_out = {1'b0, rep_out[8:1]};
	always @(tx_in[1]) rep_out = {1'b1, rep_out[8:1]};
endmodule // flash_model
